// File: rtl/ref_clock_output.sv
// ref_clock_output: reference clock output block with an AXI4-Lite
// register port, source selection, power-of-two divider and duty
// shaping, driving the output pin and an internal peripheral clock.
// assumes sources are synchronous levels and the power-management
// block supplies its module-disable bit as a level.
`timescale 1ns/1ps
`default_nettype none
module ref_clock_output
  import ref_clock_pkg::*;
(
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // axi4-lite write address
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  // axi4-lite write data
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  // axi4-lite write response
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output logic [1:0]               s_axi_bresp,
  // axi4-lite read address
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  // axi4-lite read data
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  // clock sources and device state
  input  wire clk_sources_s        sources,
  input  wire logic                sleep_active,
  input  wire logic                ref_clock_module_disable,
  // reference clock outputs
  output logic                     ref_clock_out_pin,
  output logic                     ref_clock_internal
);

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CONTROL    = ADDR_W'(IDX_CONTROL << 2);
  localparam logic [ADDR_W-1:0] ADDR_SOURCE_SEL = ADDR_W'(IDX_SOURCE_SEL << 2);
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = ADDR_W'(IDX_STATUS << 2);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    // write channel bookkeeping
    logic                awready;      // address slot free
    logic                wready;       // data slot free
    logic                aw_held;      // address captured
    logic                w_held;       // data captured
    logic [ADDR_W-1:0]   waddr;        // captured write address
    logic [7:0]          wbyte;        // captured low data byte
    logic                wlane0;       // low byte lane strobed
    logic                bvalid;       // write response pending
    logic [1:0]          bresp;        // write response code
    // read channel
    logic                arready;      // read address slot free
    logic                rvalid;       // read data pending
    logic [DATA_W-1:0]   rdata;        // read data
    logic [1:0]          rresp;        // read response code
    // software registers
    logic [7:0]          control;      // ref_clock_control
    logic [7:0]          source_sel;   // ref_clock_source_select
    // output sequencer
    out_state_e          seq;          // idle, armed or running
    logic                pin;          // pin copy of the waveform
    logic                internal;     // internal copy of the waveform
  } top_state_s;

  top_state_s  state_reg;    // registered state
  top_state_s  state_next;   // next state
  ref_config_s cfg;          // decoded control fields
  logic        half_tick;    // one source half-period elapsed
  logic        halted;       // source stopped by sleep
  logic        enabled;      // software enable and not disabled
  logic        wave_run;     // waveform counter allowed to run
  logic        wave_out;     // shaped waveform
  logic        wr_fire;      // both halves of a write present
  logic [7:0]  status_byte;  // status register contents

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------

  // control fields in their documented positions
  always_comb begin
    cfg.enable         = state_reg.control[ENABLE_BIT];
    cfg.duty_select    = state_reg.control[DUTY_LSB +: 2];
    cfg.divider_select = state_reg.control[DIVIDER_LSB +: 3];
    cfg.source_select  = state_reg.source_sel[SOURCE_LSB +: 4];
  end

  // the power-management disable bit overrides the software enable
  assign enabled = cfg.enable && !ref_clock_module_disable;

  // the counter runs once armed and the first source edge arrives;
  // waiting for that edge keeps the first high phase whole
  assign wave_run = enabled && !halted &&
                    ((state_reg.seq == OUT_RUN) ||
                     (state_reg.seq == OUT_ARM && half_tick));

  // status readback
  always_comb begin
    status_byte               = 8'h00;
    status_byte[STAT_RUN_BIT] = state_reg.seq == OUT_RUN;
    status_byte[STAT_OUT_BIT] = state_reg.pin;
    status_byte[STAT_ARM_BIT] = state_reg.seq == OUT_ARM;
  end

  // ----------------------------------------------------------------
  // clock path
  // ----------------------------------------------------------------

  // source selection and edge ticks
  ref_clock_source_mux u_mux (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .source_select (cfg.source_select),
    .sleep_active  (sleep_active),
    .sources       (sources),
    .half_tick     (half_tick),
    .source_halted (halted)
  );

  // divider and duty shaping; fields are used live, so changing them
  // while running may glitch the output, which software must avoid
  ref_clock_waveform u_wave (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .run            (wave_run),
    .half_tick      (half_tick),
    .divider_select (cfg.divider_select),
    .duty_select    (cfg.duty_select),
    .wave_out       (wave_out)
  );

  assign wr_fire = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;

    // write address and data are taken independently, in any order
    if (s_axi_awvalid && state_reg.awready) begin
      state_next.aw_held = 1'b1;
      state_next.waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.w_held = 1'b1;
      state_next.wbyte  = s_axi_wdata[7:0];
      state_next.wlane0 = s_axi_wstrb[0];
    end

    // complete a write once both halves are held
    if (wr_fire) begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = RESP_OKAY;
      case (state_reg.waddr)
        ADDR_CONTROL: begin
          // bits 6 and 5 are reserved and stay zero
          if (state_reg.wlane0) begin
            state_next.control = state_reg.wbyte & 8'h9F;
          end
        end
        ADDR_SOURCE_SEL: begin
          // upper nibble reserved
          if (state_reg.wlane0) begin
            state_next.source_sel = state_reg.wbyte & 8'h0F;
          end
        end
        ADDR_STATUS: begin
          // read-only, the write is dropped
          state_next.bresp = RESP_OKAY;
        end
        default: begin
          // unmapped address
          state_next.bresp = RESP_SLVERR;
        end
      endcase
    end

    // write response retires when accepted
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end

    // ready flags come from flops: free while its slot holds nothing and no response is pending
    state_next.awready = !state_next.aw_held && !state_next.bvalid;
    state_next.wready  = !state_next.w_held && !state_next.bvalid;

    // read: answer the cycle after the address is taken
    if (s_axi_arvalid && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CONTROL: begin
          state_next.rdata = {24'h000000, state_reg.control};
        end
        ADDR_SOURCE_SEL: begin
          state_next.rdata = {24'h000000, state_reg.source_sel};
        end
        ADDR_STATUS: begin
          state_next.rdata = {24'h000000, status_byte};
        end
        default: begin
          state_next.rdata = 32'h00000000;
          state_next.rresp = RESP_SLVERR;
        end
      endcase
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    state_next.arready = !state_next.rvalid;

    // output sequencer
    case (state_reg.seq)
      OUT_IDLE: begin
        if (enabled) begin
          state_next.seq = OUT_ARM;
        end
      end
      OUT_ARM: begin
        if (!enabled) begin
          state_next.seq = OUT_IDLE;
        end else if (half_tick && !halted) begin
          state_next.seq = OUT_RUN;
        end
      end
      OUT_RUN: begin
        if (!enabled) begin
          state_next.seq = OUT_IDLE;
        end
      end
      default: begin
        state_next.seq = OUT_IDLE;
      end
    endcase

    // both destinations get the same waveform; disabling or a
    // halted source forces low on the next edge without waiting
    // for the period to finish
    if (!enabled || halted) begin
      state_next.pin      = 1'b0;
      state_next.internal = 1'b0;
    end else begin
      state_next.pin      = wave_out;
      state_next.internal = wave_out;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg            <= '0;
      state_reg.awready    <= 1'b1;
      state_reg.wready     <= 1'b1;
      state_reg.arready    <= 1'b1;
      state_reg.control    <= CONTROL_RESET;
      state_reg.source_sel <= SOURCE_RESET;
      state_reg.seq        <= OUT_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign s_axi_awready      = state_reg.awready;
  assign s_axi_wready       = state_reg.wready;
  assign s_axi_bvalid       = state_reg.bvalid;
  assign s_axi_bresp        = state_reg.bresp;
  assign s_axi_arready      = state_reg.arready;
  assign s_axi_rvalid       = state_reg.rvalid;
  assign s_axi_rdata        = state_reg.rdata;
  assign s_axi_rresp        = state_reg.rresp;
  assign ref_clock_out_pin  = state_reg.pin;
  assign ref_clock_internal = state_reg.internal;

endmodule : ref_clock_output
`default_nettype wire

// File: rtl/ref_clock_pkg.sv
// ref_clock_pkg: constants, field layouts and carrier types of the
// reference clock output block and its AXI4-Lite register port.
// assumes a single 40 MHz bus clock; all clock sources arrive as
// levels synchronous to that clock.
package ref_clock_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 12;        // byte address width
  localparam int          DATA_W          = 32;        // bus data width
  localparam logic [1:0]  RESP_OKAY       = 2'h0;      // axi okay
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;      // axi slave error

  // ----------------------------------------------------------------
  // register indices (printed offsets); byte address is index * 4
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IDX_CONTROL    = 12'h296;  // ref_clock_control
  localparam logic [ADDR_W-1:0] IDX_SOURCE_SEL = 12'h297;  // ref_clock_source_select
  localparam logic [ADDR_W-1:0] IDX_STATUS     = 12'h298;  // running status

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         ENABLE_BIT      = 7;       // module enable
  localparam int         DUTY_LSB        = 3;       // duty_select [4:3]
  localparam int         DIVIDER_LSB     = 0;       // divider_select [2:0]
  localparam int         SOURCE_LSB      = 0;       // source code [3:0]
  localparam int         STAT_RUN_BIT    = 0;       // output running
  localparam int         STAT_OUT_BIT    = 1;       // output level
  localparam int         STAT_ARM_BIT    = 2;       // waiting for first edge
  localparam logic [7:0] CONTROL_RESET   = 8'h10;   // duty 10, div 000, off
  localparam logic [7:0] SOURCE_RESET    = 8'h00;   // system oscillator

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] DUTY_0          = 2'h0;    // constant low
  localparam logic [1:0] DUTY_25         = 2'h1;
  localparam logic [1:0] DUTY_50         = 2'h2;
  localparam logic [1:0] DUTY_75         = 2'h3;
  localparam logic [2:0] DIV_PASS        = 3'h0;    // no division
  localparam logic [3:0] SRC_SYSTEM      = 4'h0;    // system oscillator
  localparam logic [3:0] SRC_LAST_VALID  = 4'hB;    // logic cell 4

  // control fields as carried between modules
  typedef struct packed {
    logic       enable;          // software enable bit
    logic [1:0] duty_select;     // high fraction code
    logic [2:0] divider_select;  // power-of-two divider
    logic [3:0] source_select;   // clock source code
  } ref_config_s;

  // clock source levels, codes 1 to 11
  typedef struct packed {
    logic logic_cell_4_output;   // 1011
    logic logic_cell_3_output;   // 1010
    logic logic_cell_2_output;   // 1001
    logic logic_cell_1_output;   // 1000
    logic osc_controller_output; // 0111
    logic external_osc;          // 0110
    logic secondary_osc;         // 0101
    logic mid_freq_osc_32k;      // 0100
    logic mid_freq_internal_osc; // 0011
    logic low_freq_internal_osc; // 0010
    logic high_freq_internal_osc;// 0001
  } clk_sources_s;

  // run state of the output sequencer
  typedef enum logic [1:0] {
    OUT_IDLE = 2'b00,   // disabled, output low
    OUT_ARM  = 2'b01,   // enabled, waiting for a source edge
    OUT_RUN  = 2'b10    // producing the waveform
  } out_state_e;

endpackage : ref_clock_pkg

// File: rtl/ref_clock_source_mux.sv
// ref_clock_source_mux: picks one clock source and turns each of its
// edges into a one-cycle half-period tick.
// assumes every source level is synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module ref_clock_source_mux
  import ref_clock_pkg::*;
(
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // selection
  input  wire logic [3:0]    source_select,
  input  wire logic          sleep_active,
  input  wire clk_sources_s  sources,
  // result
  output logic               half_tick,
  output logic               source_halted
);

  typedef struct packed {
    logic prev;   // last sampled source level
    logic tick;   // half-period tick
  } mux_state_s;

  mux_state_s state_reg;   // registered state
  mux_state_s state_next;  // next state
  logic       level;       // selected source level

  // source selection; reserved codes read as a stopped clock
  always_comb begin
    if (source_select == SRC_SYSTEM || source_select > SRC_LAST_VALID) begin
      level = 1'b0;
    end else begin
      level = sources[source_select - 4'h1];
    end
  end

  // system oscillator halts in sleep, other sources keep running
  assign source_halted = sleep_active && (source_select == SRC_SYSTEM);

  // edge detection; the system oscillator ticks every bus cycle
  always_comb begin
    state_next      = state_reg;
    state_next.prev = level;
    if (source_select == SRC_SYSTEM) begin
      state_next.tick = !source_halted;
    end else begin
      state_next.tick = level != state_reg.prev;
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign half_tick = state_reg.tick;

endmodule : ref_clock_source_mux
`default_nettype wire

// File: rtl/ref_clock_waveform.sv
// ref_clock_waveform: counts half-periods of the source over the
// divided period and shapes the duty cycle.
// assumes run drops to clear the counter and output at once.
`timescale 1ns/1ps
`default_nettype none
module ref_clock_waveform
  import ref_clock_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // control
  input  wire logic        run,
  input  wire logic        half_tick,
  input  wire logic [2:0]  divider_select,
  input  wire logic [1:0]  duty_select,
  // result
  output logic             wave_out
);

  typedef struct packed {
    logic [7:0] count;  // half-periods into the divided period
    logic       out;    // shaped output
  } wave_state_s;

  wave_state_s state_reg;    // registered state
  wave_state_s state_next;   // next state
  logic [8:0]  period_len;   // half-periods per output period
  logic [8:0]  quarter;      // quarter of the period
  logic [8:0]  high_len;     // half-periods spent high

  // period is 2^(div+1) half-periods, i.e. the source divided by 2^div
  always_comb begin
    period_len = 9'h002 << divider_select;
    quarter    = period_len >> 2;
    if (duty_select == DUTY_0) begin
      high_len = 9'h000;
    end else if (divider_select == DIV_PASS) begin
      high_len = 9'h001;                    // fixed half duty
    end else begin
      // quarter, half or three quarters of the divided period
      high_len = 9'(quarter * {7'h00, duty_select});
    end
  end

  // counter and output; dropping run clears both in one cycle
  always_comb begin
    state_next = state_reg;
    if (!run) begin
      state_next = '0;
    end else if (half_tick) begin
      state_next.out = {1'b0, state_reg.count} < high_len;
      if ({1'b0, state_reg.count} >= period_len - 9'h001) begin
        state_next.count = 8'h00;
      end else begin
        state_next.count = state_reg.count + 8'h01;
      end
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wave_out = state_reg.out;

endmodule : ref_clock_waveform
`default_nettype wire

// File: test/ref_clock_output_monitor.sv
// ref_clock_output_monitor: bus and output assertions.
// assumes it is bound to every instance of ref_clock_output.
`timescale 1ns/1ps
`default_nettype none
module ref_clock_output_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // device state and outputs
  input wire logic ref_clock_module_disable,
  input wire logic ref_clock_out_pin,
  input wire logic ref_clock_internal
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both copies of the clock must agree or peripherals drift from the pin
  pin_matches_a: assert property (ref_clock_out_pin == ref_clock_internal)
    else $error("pin and internal clock differ");
  disable_stops_a: assert property (ref_clock_module_disable |=> !ref_clock_out_pin)
    else $error("output not low while module disabled");
  rise_enabled_a: assert property ($rose(ref_clock_out_pin)
    |-> $past(!ref_clock_module_disable)) else $error("output rose while module disabled");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped early");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  // main scenarios reached
  cover property ($rose(ref_clock_out_pin));
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($rose(ref_clock_module_disable));
endmodule : ref_clock_output_monitor
bind ref_clock_output ref_clock_output_monitor mon (.*);
`default_nettype wire

// File: test/ref_clock_source_model.sv
// ref_clock_source_model: far-side clock sources for the bench.
// assumes levels change just after rising aclk edges.
`timescale 1ns/1ps
`default_nettype none
module ref_clock_source_model
  import ref_clock_pkg::*;
(
  // clock and control
  input  wire logic       aclk,
  input  wire logic [3:0] live,
  // source levels
  output clk_sources_s    sources
);
  // ------------------------
  // toggle generator
  // ------------------------
  logic [1:0] cnt_reg = 2'h0;  // free divider, level flips every 2 cycles
  always_ff @(posedge aclk) begin
    cnt_reg <= cnt_reg + 2'h1;
  end
  // only the live source runs; others rest low so a wrong pick shows
  always_comb begin
    sources = '0;
    if (live != 4'h0 && live <= SRC_LAST_VALID) begin
      sources[live - 4'h1] = cnt_reg[1];
    end
  end
endmodule : ref_clock_source_model
`default_nettype wire

// File: test/reference_clock_output_bench.sv
// reference_clock_output_bench: self-checking bench of the block.
// assumes the source model flips the live source every two cycles.
`timescale 1ns/1ps
`default_nettype none
module reference_clock_output_bench;
  import ref_clock_pkg::*;
  // ------------------------
  // signals
  // ------------------------
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic sleep_active, ref_clock_module_disable, ref_clock_out_pin, ref_clock_internal;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb, live;
  logic [2:0]        s_axi_awprot, s_axi_arprot;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  clk_sources_s      sources;
  int                errors, cmp_count, cyc;
  localparam logic [11:0] CTL = IDX_CONTROL << 2;     // control byte address
  localparam logic [11:0] SRC = IDX_SOURCE_SEL << 2;  // source byte address
  ref_clock_output dut (.*);
  ref_clock_source_model model (.aclk, .live, .sources);
  // ------------------------
  // shared tasks
  // ------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // one write, response judged here
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic done = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
      end
    end
    @(posedge aclk);  // spacer: bready set once per edge
  endtask : wr
  // one read, data and response judged here
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    logic done = 1'b0;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= a;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        done = 1'b1;
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
      end
    end
    @(posedge aclk);
  endtask : rd
  // settle a full long period, then count highs and rises over 256 cycles
  task automatic meas(input int ehi, input int erise);
    int hi = 0, rise = 0;
    logic prev;
    repeat (260) @(posedge aclk);
    prev = ref_clock_out_pin;
    repeat (256) begin
      @(posedge aclk);
      if (ref_clock_out_pin === 1'b1) hi++;
      if (ref_clock_out_pin === 1'b1 && prev === 1'b0) rise++;
      prev = ref_clock_out_pin;
    end
    chk(hi, ehi);
    chk(rise, erise);
  endtask : meas
  // ------------------------
  // scenarios
  // ------------------------
  task automatic t_reset;
    rd(CTL, 32'h10);
    rd(SRC, 32'h0);
    rd(12'hA64, 32'h0, RESP_SLVERR);
    wr(CTL, 8'h7F);
    wr(12'hA64, 8'h80, RESP_SLVERR);
    rd(CTL, 32'h1F);
    meas(0, 0);
  endtask : t_reset
  // every divider and duty code, stopped mid-waveform each time
  task automatic t_div;
    for (int v = 0; v < 32; v++) begin
      wr(CTL, 8'(v));
      wr(CTL, 8'(v) | 8'h80);
      meas(v[4:3] == 0 ? 0 : v[2:0] == 0 ? 128 : 64 * v[4:3],
           v[4:3] == 0 ? 0 : 128 >> v[2:0]);
      wr(CTL, 8'(v));
      chk({31'h0, ref_clock_out_pin}, 32'h0);
    end
  endtask : t_div
  // first high phase after enabling must be whole: 6 of 8 cycles
  task automatic t_first;
    int n;
    n = 0;
    wr(CTL, 8'h1A);
    wr(CTL, 8'h9A);
    while (ref_clock_out_pin !== 1'b1 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    n = 0;
    while (ref_clock_out_pin === 1'b1 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    chk(n, 6);
    wr(CTL, 8'h10);
  endtask : t_first
  // every source code; code 3 sees a wrong source running
  task automatic t_src;
    for (int c = 0; c < 16; c++) begin
      live <= (c == 3) ? 4'h4 : 4'(c);
      wr(SRC, 8'(c));
      rd(SRC, 32'(c));
      wr(CTL, 8'h90);
      meas(c < 12 && c != 3 ? 128 : 0, c == 0 ? 128 : c < 12 && c != 3 ? 64 : 0);
      wr(CTL, 8'h10);
    end
  endtask : t_src
  // halted system source leaves the sequencer armed, status 0x04
  task automatic t_sleep;
    sleep_active <= 1'b1;
    wr(SRC, 8'h00);
    wr(CTL, 8'h90);
    meas(0, 0);
    rd(IDX_STATUS << 2, 32'h4);
    wr(CTL, 8'h10);
    live <= 4'h5;
    wr(SRC, 8'h05);
    wr(CTL, 8'h90);
    meas(128, 64);
    sleep_active <= 1'b0;
    wr(CTL, 8'h10);
  endtask : t_sleep
  task automatic t_pmd;
    ref_clock_module_disable <= 1'b1;
    wr(SRC, 8'h00);
    wr(CTL, 8'h90);
    meas(0, 0);
    ref_clock_module_disable <= 1'b0;
    meas(128, 128);
  endtask : t_pmd
  task automatic results;
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  // ------------------------
  // clock, watchdog and main sequence
  // ------------------------
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // the run needs about 28000 cycles; over twice that means a hang
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 64000) begin
      errors++;
      results();
    end
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot, live} = '0;
    {s_axi_wstrb, sleep_active, ref_clock_module_disable} = 6'h3C;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_div();
    t_first();
    t_src();
    t_sleep();
    t_pmd();
    results();
  end
endmodule : reference_clock_output_bench
`default_nettype wire
